// file: src/mccs_cfg.svh
// Purpose: shared constants of the conversion sequencer and its serial slave
// Assumes: one 10 MHz clock
// Notes:   times are in their own unit, cycle counts are derived in the top
`ifndef MCCS_CFG_SVH
`define MCCS_CFG_SVH
`define CLK_MHZ       10
`define SLOTS         6
`define CNT_W         17
`define CT0_US        140
`define CT1_US        204
`define CT2_US        332
`define CT3_US        588
`define CT4_US        1100
`define CT5_US        2116
`define CT6_US        4156
`define CT7_US        8244
`define TMO_MS        28
`define TMO_W         19
`define MODE_SHUNT_B  0
`define MODE_BUS_B    1
`define MODE_CONT_B   2
`define SLV_ADDR      7'h40
`define BYTE_BITS     4'h8
`endif

// file: src/mccs_pkg.sv
// Purpose: types shared by the sequencer top and its ports
// Assumes: nothing beyond the constants header
// Notes:   mode bit 0 shunt, bit 1 bus, bit 2 continuous
package mccs_pkg;
    typedef struct packed {
        logic [2:0] ch_en;
        logic [2:0] mode;
        logic [2:0] shunt_ct;
        logic [2:0] bus_ct;
        logic [2:0] avg;
    } mccs_cfg_t;

    typedef struct packed {
        logic       active;
        logic [1:0] ch;
        logic       is_bus;
    } mccs_conv_t;

    typedef enum logic [0:0] {SQ_IDLE, SQ_CONV} mccs_sq_t;

    typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_ACK, I2_RX, I2_TX, I2_TXACK} mccs_i2_t;
endpackage : mccs_pkg

// file: src/mccs_sync2.sv
// Purpose: two flip-flop synchroniser for asynchronous pin inputs
// Assumes: inputs idle at INIT
// Notes:   first stage is read by the second stage only
module mccs_sync2 #(
    parameter int unsigned    W    = 1,
    parameter logic [W-1:0]   INIT = '1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= INIT;
            q      <= INIT;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : mccs_sync2

// file: src/mccs_top.sv
// Purpose: round-robin conversion sequencer with two-wire serial slave
// Assumes: converter presents its result in the last cycle of a conversion
// Notes:   config bits are plain ports; SCL and SDA are synchronised first
`include "mccs_cfg.svh"
// Operation
// - convert enabled slots in fixed repeating order
// - all six enabled: five others between repeats
// - shunt only, three channels: two others between
// - full sequence lasts three times shunt plus bus
// - separate shunt and bus times, same per channel
// - single slot restarts with no idle gap
// - conversion length set only by its time setting
// - conversion times span 140 us to 8.244 ms
// - averaging setting independent of conversion times
// - critical check uses each unaveraged shunt result
// - start is SDA falling while SCL high
// - address bits sampled on SCL rise, last is direction
// - acknowledge address by pulling SDA on ninth pulse
// - eight data bits then receiver acknowledge
// - SDA change with SCL high is start or stop
// - 28 ms timeout abandons a stalled transfer
// - sequence begins at lowest enabled slot
// - channel enables and mode bits pick slots
module mccs_top #(
    parameter int unsigned CNT_W       = `CNT_W,
    parameter int unsigned CT_CYC [8]  = '{`CT0_US * `CLK_MHZ, `CT1_US * `CLK_MHZ,
                                          `CT2_US * `CLK_MHZ, `CT3_US * `CLK_MHZ,
                                          `CT4_US * `CLK_MHZ, `CT5_US * `CLK_MHZ,
                                          `CT6_US * `CLK_MHZ, `CT7_US * `CLK_MHZ},
    parameter int unsigned TMO_CYC     = `TMO_MS * 1000 * `CLK_MHZ,
    parameter logic [6:0]  SLV_ADDR    = `SLV_ADDR
) (
    input  wire logic                 MCLK,
    input  wire logic                 RST_N,
    input  wire mccs_pkg::mccs_cfg_t  CFG,
    input  wire logic                 TRIG,
    input  wire logic [15:0]          ADC_DATA,
    input  wire logic [15:0]          CRIT_LIMIT,
    input  wire logic                 SCL_I,
    input  wire logic                 SDA_I,
    output      logic                 SDA_O,
    output      logic                 SDA_OE,
    output var  mccs_pkg::mccs_conv_t CONV,
    output      logic                 CONV_DONE,
    output      logic [15:0]          RESULT,
    output      logic [2:0]           AVG_CODE,
    output      logic                 CRIT_ALERT
);
    import mccs_pkg::*;

    default clocking dc @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    // slot s: channel s/2, bus when s is odd
    function automatic logic [2:0] next_slot(input logic [2:0] cur, input logic [5:0] e);
        logic [2:0] r;
        logic       hit;
        int         idx;
        r   = cur;
        hit = 1'b0;
        for (int i = 1; i <= `SLOTS; i++) begin
            idx = (int'(cur) + i) % `SLOTS;
            if (!hit && e[idx]) begin
                r   = 3'(idx);
                hit = 1'b1;
            end
        end
        return r;
    endfunction : next_slot

    function automatic logic [CNT_W-1:0] ct_len(input logic [2:0] code);
        return CNT_W'(CT_CYC[code]);
    endfunction : ct_len

    mccs_sq_t         sq_state_r;
    logic [2:0]       slot_r;
    logic [2:0]       dslot_r;
    logic [CNT_W-1:0] cnt_r;
    logic             strt_r;
    logic [5:0]       en;
    logic [5:0]       en_q_r;
    logic             cont;
    logic             end_cyc;
    logic [2:0]       first;
    logic [2:0]       nxt;

    always_comb begin
        for (int s = 0; s < `SLOTS; s++) begin
            en[s] = CFG.ch_en[s / 2] &
                    ((s % 2 == 1) ? CFG.mode[`MODE_BUS_B] : CFG.mode[`MODE_SHUNT_B]);
        end
    end

    assign cont    = CFG.mode[`MODE_CONT_B];
    assign end_cyc = (sq_state_r == SQ_CONV) && (cnt_r == CNT_W'(1));
    assign first   = next_slot(3'(`SLOTS - 1), en);
    assign nxt     = next_slot(slot_r, en);

    // sequencer: next slot loads in the same edge the last one ends
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sq_state_r <= SQ_IDLE;
            slot_r     <= 3'h0;
            dslot_r    <= 3'h0;
            cnt_r      <= '0;
            strt_r     <= 1'b0;
            CONV       <= '0;
            CONV_DONE  <= 1'b0;
        end else begin
            strt_r    <= 1'b0;
            CONV_DONE <= 1'b0;
            unique case (sq_state_r)
                SQ_IDLE: begin
                    if (|en && (cont || TRIG)) begin
                        sq_state_r <= SQ_CONV;
                        slot_r     <= first;
                        cnt_r      <= ct_len(first[0] ? CFG.bus_ct : CFG.shunt_ct);
                        strt_r     <= 1'b1;
                        CONV       <= '{active: 1'b1, ch: first[2:1], is_bus: first[0]};
                    end
                end
                SQ_CONV: begin
                    if (end_cyc) begin
                        CONV_DONE <= 1'b1;
                        dslot_r   <= slot_r;
                        // single shot stops once the order wraps
                        if (!(|en) || (!cont && nxt <= slot_r)) begin
                            sq_state_r <= SQ_IDLE;
                            CONV       <= '0;
                        end else begin
                            slot_r <= nxt;
                            cnt_r  <= ct_len(nxt[0] ? CFG.bus_ct : CFG.shunt_ct);
                            strt_r <= 1'b1;
                            CONV   <= '{active: 1'b1, ch: nxt[2:1], is_bus: nxt[0]};
                        end
                    end else begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // results; averaging code travels beside each result for the averager
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            RESULT     <= 16'h0000;
            AVG_CODE   <= 3'h0;
            CRIT_ALERT <= 1'b0;
        end else if (end_cyc) begin
            RESULT   <= ADC_DATA;
            AVG_CODE <= CFG.avg;
            if (!slot_r[0]) begin
                CRIT_ALERT <= ADC_DATA > CRIT_LIMIT;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            en_q_r <= 6'h00;
        end else begin
            en_q_r <= en;
        end
    end

    // serial slave
    logic             scl_s;
    logic             sda_s;
    logic             scl_p;
    logic             sda_p;
    logic             start_det;
    logic             stop_det;
    logic             rise;
    logic             fall;
    logic [`TMO_W-1:0] tmo_r;
    logic             tmo_hit;
    mccs_i2_t         i2_state_r;
    logic [3:0]       bit_r;
    logic [7:0]       sh_r;
    logic             rw_r;
    logic             hi_r;
    logic [15:0]      tx_r;
    logic [7:0]       tx_byte;

    mccs_sync2 #(
        .W    (2),
        .INIT (2'h3)
    ) u_sync (
        .clk   (MCLK),
        .rst_n (RST_N),
        .d     ({SCL_I, SDA_I}),
        .q     ({scl_s, sda_s})
    );

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    assign start_det = scl_s && scl_p && sda_p && !sda_s;
    assign stop_det  = scl_s && scl_p && !sda_p && sda_s;
    assign rise      = scl_s && !scl_p;
    assign fall      = !scl_s && scl_p;
    assign tmo_hit   = tmo_r == `TMO_W'(TMO_CYC - 1);
    assign tx_byte   = hi_r ? tx_r[15:8] : tx_r[7:0];

    // lock-up guard: counts while a transfer is open and SCL sits low
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            tmo_r <= '0;
        end else if (i2_state_r == I2_IDLE || scl_s || tmo_hit) begin
            tmo_r <= '0;
        end else begin
            tmo_r <= tmo_r + `TMO_W'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            i2_state_r <= I2_IDLE;
            bit_r      <= 4'h0;
            sh_r       <= 8'h00;
            rw_r       <= 1'b0;
            hi_r       <= 1'b1;
            tx_r       <= 16'h0000;
            SDA_OE     <= 1'b0;
            SDA_O      <= 1'b0;
        end else if (start_det) begin
            i2_state_r <= I2_ADDR;
            bit_r      <= 4'h0;
            SDA_OE     <= 1'b0;
        end else if (stop_det || tmo_hit) begin
            i2_state_r <= I2_IDLE;
            SDA_OE     <= 1'b0;
        end else begin
            unique case (i2_state_r)
                I2_IDLE: begin
                end
                I2_ADDR, I2_RX: begin
                    if (rise) begin
                        sh_r  <= {sh_r[6:0], sda_s};
                        bit_r <= bit_r + 4'h1;
                    end else if (fall && bit_r == `BYTE_BITS) begin
                        bit_r <= 4'h0;
                        if (i2_state_r == I2_RX) begin
                            rw_r       <= 1'b0;
                            SDA_OE     <= 1'b1;
                            i2_state_r <= I2_ACK;
                        end else if (sh_r[7:1] == SLV_ADDR) begin
                            rw_r       <= sh_r[0];
                            tx_r       <= RESULT;
                            hi_r       <= 1'b1;
                            SDA_OE     <= 1'b1;
                            i2_state_r <= I2_ACK;
                        end else begin
                            i2_state_r <= I2_IDLE;
                        end
                    end
                end
                I2_ACK: begin
                    if (fall) begin
                        if (rw_r) begin
                            sh_r       <= tx_byte;
                            SDA_OE     <= !tx_byte[7];
                            hi_r       <= !hi_r;
                            i2_state_r <= I2_TX;
                        end else begin
                            SDA_OE     <= 1'b0;
                            i2_state_r <= I2_RX;
                        end
                    end
                end
                I2_TX: begin
                    if (rise) begin
                        bit_r <= bit_r + 4'h1;
                    end else if (fall) begin
                        if (bit_r == `BYTE_BITS) begin
                            bit_r      <= 4'h0;
                            SDA_OE     <= 1'b0;
                            i2_state_r <= I2_TXACK;
                        end else begin
                            sh_r   <= {sh_r[6:0], 1'b0};
                            SDA_OE <= !sh_r[6];
                        end
                    end
                end
                I2_TXACK: begin
                    // a not-acknowledge from the master ends the read
                    if (rise && sda_s) begin
                        i2_state_r <= I2_IDLE;
                    end else if (fall) begin
                        sh_r       <= tx_byte;
                        SDA_OE     <= !tx_byte[7];
                        hi_r       <= !hi_r;
                        i2_state_r <= I2_TX;
                    end
                end
            endcase
        end
    end

    AST_SLOT_ENABLED: assert property (
        strt_r |-> (en_q_r & (6'h01 << slot_r)) != 6'h00)
        else $error("started a slot that was not enabled");

    AST_NO_GAP: assert property (
        end_cyc && cont && |en |=> strt_r && sq_state_r == SQ_CONV)
        else $error("gap between continuous conversions");

    AST_CONV_LEN: assert property (
        strt_r |-> cnt_r == ct_len(slot_r[0] ? $past(CFG.bus_ct) : $past(CFG.shunt_ct)))
        else $error("conversion length not from its time setting");

    AST_SHUNT_THEN_BUS: assert property (
        CONV_DONE && !dslot_r[0] && en_q_r[dslot_r | 3'h1] && sq_state_r == SQ_CONV
        |-> slot_r == (dslot_r | 3'h1))
        else $error("bus did not follow shunt in the same channel");

    AST_SEQ_FIRST: assert property (
        strt_r && $past(sq_state_r) == SQ_CONV && slot_r <= dslot_r
        |-> slot_r == next_slot(3'h5, en_q_r))
        else $error("new sequence did not begin at lowest enabled slot");

    AST_CRIT_RAW: assert property (
        end_cyc && !slot_r[0] && ADC_DATA > CRIT_LIMIT |=> CRIT_ALERT)
        else $error("critical alert missed a single result");

    AST_START: assert property (
        start_det |=> i2_state_r == I2_ADDR && bit_r == 4'h0 && !SDA_OE)
        else $error("start not recognised");

    AST_ADDR_SHIFT: assert property (
        i2_state_r == I2_ADDR && rise && !start_det && !stop_det && !tmo_hit
        |=> sh_r[0] == $past(sda_s) && bit_r == $past(bit_r) + 4'h1)
        else $error("address bit not sampled on rising clock");

    AST_ADDR_ACK: assert property (
        i2_state_r == I2_ADDR && fall && bit_r == `BYTE_BITS && sh_r[7:1] == SLV_ADDR
        && !start_det && !stop_det && !tmo_hit |=> SDA_OE && i2_state_r == I2_ACK)
        else $error("matching address not acknowledged");

    AST_STOP: assert property (
        stop_det && !start_det |=> i2_state_r == I2_IDLE && !SDA_OE)
        else $error("stop did not return to idle");

    AST_TIMEOUT: assert property (
        tmo_hit && !start_det |=> i2_state_r == I2_IDLE && !SDA_OE && tmo_r == '0)
        else $error("timeout did not release the bus");
endmodule : mccs_top

// file: test/mccs_i2c_master.sv
// Purpose: two-wire bus master model facing the serial slave
// Assumes: line is pulled up unless a party pulls it low
// Notes:   800 ns bit period; scl parks low after start and byte calls, which is how a stall is made
module mccs_i2c_master (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // works from scl high or low, so it also serves as a repeated start
    task automatic start_c;
        #37 sda_low = 1'b0;
        #200 scl = 1'b1;
        #200 sda_low = 1'b1;
        #200 scl = 1'b0;
        #200;
    endtask : start_c

    task automatic stop_c;
        sda_low = 1'b1;
        #200 scl = 1'b1;
        #200 sda_low = 1'b0;
        #400;
    endtask : stop_c

    // data moves only while scl is low
    task automatic bit_c(input logic b, output logic r);
        sda_low = ~b;
        #200 scl = 1'b1;
        #200 r = sda;
        #200 scl = 1'b0;
        #200;
    endtask : bit_c

    task automatic byte_c(input  logic [7:0] d,
                          input  logic       a,
                          output logic [7:0] q,
                          output logic       ar);
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], q[i]);
        end
        bit_c(a, ar);
        sda_low = 1'b0;
    endtask : byte_c
endmodule : mccs_i2c_master

// file: test/mccs_top_bench.sv
// Purpose: self-checking bench of the conversion sequencer and serial slave
// Assumes: shortened conversion and timeout counts
// Notes:   durations are taken from the load edge, then between done pulses, so no load offset enters the counts
module mccs_top_bench import mccs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned CT [8] = '{20, 30, 40, 50, 60, 70, 80, 90};
    localparam int unsigned TMO    = 2000;

    logic        MCLK  = 1'b0;
    logic        RST_N = 1'b0;
    logic        trig  = 1'b0;
    mccs_cfg_t   CFG   = '0;
    logic [15:0] ADC   = 16'h1234;
    logic [15:0] LIM   = 16'h1000;
    logic        SDA_OE, SDA_O, CONV_DONE, CRIT_ALERT, scl, m_low, sda;
    mccs_conv_t  CONV;
    logic [15:0] RESULT;
    logic [2:0]  AVG_CODE;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc       = 0;

    always #50 MCLK = ~MCLK;
    assign sda = ~(SDA_OE | m_low);

    mccs_top #(.CT_CYC(CT), .TMO_CYC(TMO)) i_mccs_top (
        .MCLK(MCLK), .RST_N(RST_N), .CFG(CFG), .TRIG(trig), .ADC_DATA(ADC), .CRIT_LIMIT(LIM),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .CONV(CONV),
        .CONV_DONE(CONV_DONE), .RESULT(RESULT), .AVG_CODE(AVG_CODE), .CRIT_ALERT(CRIT_ALERT));
    mccs_i2c_master i_mccs_i2c_master (.scl(scl), .sda_low(m_low), .sda(sda));

    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_slot(input mccs_conv_t got, input mccs_conv_t exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t slot %h expected %h", $time, got, exp);
        end
    endtask : chk_slot

    task automatic tick;
        @(posedge MCLK);
        #1;
    endtask : tick

    function automatic int nxt(mccs_cfg_t c, int s);
        int t;
        for (int k = 1; k <= 6; k++) begin
            t = (s + k) % 6;
            if (c.ch_en[t / 2] && c.mode[t % 2]) return t;
        end
        return s;
    endfunction : nxt

    function automatic mccs_conv_t mk(int s);
        return '{active: 1'b1, ch: 2'(s / 2), is_bus: 1'(s % 2)};
    endfunction : mk

    // bounded wait; returns the cycles it took
    task automatic wait_done(output int k);
        k = 0;
        do begin
            tick();
            k++;
        end while (CONV_DONE !== 1'b1 && k < 200);
    endtask : wait_done

    // idle first, so the old setting cannot leak into the new order
    task automatic run_seq(input mccs_cfg_t c, input int n, input logic alrt, output int tot);
        int s, k;
        tick();
        CFG = '0;
        k = 0;
        while (CONV.active !== 1'b0 && k < 200) begin
            tick();
            k++;
        end
        CFG = c;
        k = 0;
        // stop at the load edge, so each done-to-done count is one conversion
        while (CONV.active !== 1'b1 && k < 200) begin
            tick();
            k++;
        end
        s   = nxt(c, 5);
        tot = 0;
        chk_slot(CONV, mk(s));
        for (int i = 0; i < n; i++) begin
            wait_done(k);
            tot += k;
            chk(16'(k), 16'(CT[(s % 2) ? c.bus_ct : c.shunt_ct]));
            chk(RESULT, ADC);
            chk({13'h0, AVG_CODE}, {13'h0, c.avg});
            if (s % 2 == 0) chk({15'h0, CRIT_ALERT}, {15'h0, alrt});
            s = nxt(c, s);
            chk_slot(CONV, mk(s));
        end
    endtask : run_seq

    // single shot: one trigger runs the order once, then the sequencer idles
    task automatic single;
        int k;
        tick();
        CFG = '0;
        k = 0;
        while (CONV.active !== 1'b0 && k < 200) begin
            tick();
            k++;
        end
        CFG = '{ch_en: 3'h1, mode: 3'h3, shunt_ct: 3'h0, bus_ct: 3'h0, avg: 3'h1};
        tick();
        chk_slot(CONV, '0);
        trig = 1'b1;
        tick();
        trig = 1'b0;
        chk_slot(CONV, mk(0));
        wait_done(k);
        chk_slot(CONV, mk(1));
        wait_done(k);
        chk_slot(CONV, '0);
    endtask : single

    task automatic xfer(input logic [6:0] a, input logic wr, input logic ack, input logic [15:0] exp);
        logic [7:0] h, l;
        logic       r;
        i_mccs_i2c_master.start_c();
        i_mccs_i2c_master.byte_c({a, wr ? 1'b0 : 1'b1}, 1'b1, h, r);
        chk({15'h0, r}, {15'h0, ~ack});
        if (ack && wr) begin
            i_mccs_i2c_master.byte_c(8'hA5, 1'b1, h, r);
            chk({15'h0, r}, 16'h0);
        end else if (ack) begin
            i_mccs_i2c_master.byte_c(8'hFF, 1'b0, h, r);
            i_mccs_i2c_master.byte_c(8'hFF, 1'b1, l, r);
            chk({h, l}, exp);
        end
        i_mccs_i2c_master.stop_c();
    endtask : xfer

    // stall with the slave pulling sda for bit 7 of 8'h12
    task automatic stall;
        logic [7:0] q;
        logic       r;
        i_mccs_i2c_master.start_c();
        i_mccs_i2c_master.byte_c({7'h40, 1'b1}, 1'b1, q, r);
        repeat (10) tick();
        chk({15'h0, SDA_OE}, 16'h1);
        repeat (TMO + 20) tick();
        chk({15'h0, SDA_OE}, 16'h0);
        chk({15'h0, SDA_O}, 16'h0);
        xfer(7'h40, 1'b0, 1'b1, 16'h1234);
    endtask : stall

    initial begin
        int t;
        repeat (3) @(posedge MCLK);
        #1 RST_N = 1'b1;
        tick();
        chk({11'h0, CONV, SDA_OE}, 16'h0);
        repeat (3) tick();
        run_seq('{ch_en: 3'h7, mode: 3'h7, shunt_ct: 3'h0, bus_ct: 3'h3, avg: 3'h5}, 12, 1'b1, t);
        chk(16'(t), 16'(2 * 3 * (CT[0] + CT[3])));
        LIM = 16'hFFFF;
        run_seq('{ch_en: 3'h7, mode: 3'h5, shunt_ct: 3'h7, bus_ct: 3'h0, avg: 3'h2}, 6, 1'b0, t);
        run_seq('{ch_en: 3'h2, mode: 3'h6, shunt_ct: 3'h0, bus_ct: 3'h1, avg: 3'h7}, 4, 1'b0, t);
        run_seq('{ch_en: 3'h5, mode: 3'h7, shunt_ct: 3'h1, bus_ct: 3'h2, avg: 3'h0}, 8, 1'b0, t);
        single();
        run_seq('{ch_en: 3'h7, mode: 3'h7, shunt_ct: 3'h0, bus_ct: 3'h0, avg: 3'h0}, 1, 1'b0, t);
        xfer(7'h40, 1'b0, 1'b1, 16'h1234);
        xfer(7'h40, 1'b1, 1'b1, 16'h0);
        xfer(7'h41, 1'b0, 1'b0, 16'h0);
        stall();
        summarize();
    end
endmodule : mccs_top_bench
